// ---- design/dcfm_monitor.v ----
/*
 * Dual channel safety fault monitor: cross-compares safety states of two
 * channels, watches the selection input for chattering, latches the
 * channel-defect fault with its fault value until fail-safe acknowledge arrives while no fault cause is present.
 * Assumes one 40 MHz clock; channel inputs and selection come from pins.
 */
`include "dcfm_defs.vh"

module dcfm_monitor #(
    parameter TOL_W   = `DCFM_TOL_W,
    parameter TOL_CYC = `DCFM_TOL_CYC_DEF
) (
    input  wire                   clk,
    input  wire                   sys_rst,
    input  wire [TOL_W-1:0]       changeover_tolerance_time,
    input  wire                   failsafe_digital_input,
    input  wire                   failsafe_ack,
    input  wire                   ch2_stop_req,
    input  wire                   xchk_err,
    input  wire [9:0]             xchk_code,
    input  wire                   sto_sel_ch1,
    input  wire                   sto_sel_ch2,
    input  wire                   pulse_cb_ch1,
    input  wire                   pulse_cb_ch2,
    input  wire                   ssd_tmr_ch1,
    input  wire                   ssd_tmr_ch2,
    input  wire                   sto_term_p1,
    input  wire                   sto_term_p2,
    output reg                    chan_defect_fault,
    output reg  [`DCFM_FV_W-1:0]  fault_value,
    output reg                    stop_a_fault,
    output reg  [`DCFM_FV_W-1:0]  stop_a_value,
    output reg                    sel_monitor_active
);
    // ==========================================================
    // Input synchronisation
    // ==========================================================
    wire [11:0] sync_in;
    wire [11:0] sync_out;

    assign sync_in = {failsafe_digital_input, failsafe_ack, ch2_stop_req, xchk_err,
                      sto_sel_ch1, sto_sel_ch2, pulse_cb_ch1, pulse_cb_ch2,
                      ssd_tmr_ch1, ssd_tmr_ch2, sto_term_p1, sto_term_p2};

    dcfm_sync #(
        .W (12)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (sync_in),
        .q       (sync_out)
    );

    wire sel   = sync_out[11];
    wire ack   = sync_out[10];
    wire stop2 = sync_out[9];
    wire xerr  = sync_out[8];
    wire d_sto = sync_out[7] ^ sync_out[6];
    wire d_pcb = sync_out[5] ^ sync_out[4];
    wire d_ssd = sync_out[3] ^ sync_out[2];
    wire d_trm = sync_out[1] ^ sync_out[0];

    reg [9:0] xcode_s1;
    reg [9:0] xcode;

    // Code travels with its strobe through the same two stages
    always @(posedge clk) begin
        if (sys_rst) begin
            xcode_s1 <= 10'h000;
            xcode    <= 10'h000;
        end else begin
            xcode_s1 <= xchk_code;
            xcode    <= xcode_s1;
        end
    end

    // ==========================================================
    // Tolerance limits
    // ==========================================================
    function [TOL_W-1:0] clamp_tol;
        input [TOL_W-1:0] t;
        begin
            clamp_tol = (t == {TOL_W{1'b0}}) ? {{(TOL_W-1){1'b0}}, 1'b1} : t;
        end
    endfunction

    reg  [TOL_W-1:0] tol;
    wire [TOL_W+2:0] chk_lim = tol * 3'd`DCFM_CHK_MULT;

    // ==========================================================
    // Selection chatter monitor
    // ==========================================================
    localparam ST_IDLE = 3'b001;
    localparam ST_MON  = 3'b010;
    localparam ST_INIT = 3'b100;

    reg [2:0]       state;
    reg             sel_d;
    reg [TOL_W-1:0] chg_tmr;
    reg [TOL_W+2:0] chk_tmr;
    reg             init_bad_chg;
    reg             init_bad_chk;
    reg             chatter_trip;

    wire sel_edge = sel ^ sel_d;

    always @(posedge clk) begin
        if (sys_rst) begin
            state        <= ST_INIT;
            sel_d        <= 1'b0;
            chg_tmr      <= {TOL_W{1'b0}};
            chk_tmr      <= {(TOL_W+3){1'b0}};
            tol          <= {TOL_W{1'b0}};
            init_bad_chg <= 1'b0;
            init_bad_chk <= 1'b0;
            chatter_trip <= 1'b0;
        end else begin
            sel_d        <= sel;
            chatter_trip <= 1'b0;
            init_bad_chg <= 1'b0;
            init_bad_chk <= 1'b0;
            case (state)
                ST_INIT: begin
                    // Timers must start from zero; anything else is a fault
                    tol          <= clamp_tol(changeover_tolerance_time);
                    init_bad_chg <= (chg_tmr != {TOL_W{1'b0}});
                    init_bad_chk <= (chk_tmr != {(TOL_W+3){1'b0}});
                    state        <= ST_IDLE;
                end
                ST_IDLE: begin
                    tol <= clamp_tol(changeover_tolerance_time);
                    if (sel_edge) begin
                        chg_tmr <= {TOL_W{1'b0}};
                        chk_tmr <= {(TOL_W+3){1'b0}};
                        state   <= ST_MON;
                    end
                end
                ST_MON: begin
                    chk_tmr <= chk_tmr + 1'b1;
                    if (sel_edge) begin
                        chg_tmr <= {TOL_W{1'b0}};
                    end else begin
                        chg_tmr <= chg_tmr + 1'b1;
                    end
                    if (!sel_edge && chg_tmr >= tol) begin
                        state <= ST_IDLE;
                    end else if (chk_tmr + 1'b1 >= chk_lim) begin
                        chatter_trip <= 1'b1;
                        state        <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_INIT;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            sel_monitor_active <= 1'b0;
        end else begin
            sel_monitor_active <= (state == ST_MON);
        end
    end

    // ==========================================================
    // Discrepancy filters
    // ==========================================================
    // Discrepancy must persist past the tolerance before it counts
    reg [TOL_W-1:0] dis_cnt [0:3];
    reg [3:0]       dis_hit;
    wire [3:0]      dis_raw = {d_trm, d_ssd, d_pcb, d_sto};
    integer i;

    always @(posedge clk) begin
        if (sys_rst) begin
            for (i = 0; i < 4; i = i + 1) begin
                dis_cnt[i] <= {TOL_W{1'b0}};
            end
            dis_hit <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (!dis_raw[i]) begin
                    dis_cnt[i] <= {TOL_W{1'b0}};
                    dis_hit[i] <= 1'b0;
                end else if (dis_cnt[i] >= tol) begin
                    dis_hit[i] <= 1'b1;
                end else begin
                    dis_cnt[i] <= dis_cnt[i] + 1'b1;
                    dis_hit[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Fault cause priority and latch
    // ==========================================================
    reg                   cause;
    reg [`DCFM_FV_W-1:0]  cause_val;

    always @* begin
        cause     = 1'b1;
        cause_val = `DCFM_FV_STOP_REQ;
        if (stop2) begin
            cause_val = `DCFM_FV_STOP_REQ;
        end else if (xerr) begin
            if (xcode == 10'h000) begin
                cause_val = 14'h0001;
            end else if ({4'h0, xcode} > `DCFM_FV_XCHK_MAX) begin
                cause_val = `DCFM_FV_XCHK_MAX;
            end else begin
                cause_val = {4'h0, xcode};
            end
        end else if (chatter_trip) begin
            cause_val = `DCFM_FV_CHATTER;
        end else if (init_bad_chg) begin
            cause_val = `DCFM_FV_INIT_CHG;
        end else if (init_bad_chk) begin
            cause_val = `DCFM_FV_INIT_CHK;
        end else if (dis_hit[0]) begin
            cause_val = `DCFM_FV_STO_SEL;
        end else if (dis_hit[1]) begin
            cause_val = `DCFM_FV_PULSE_CB;
        end else if (dis_hit[2]) begin
            cause_val = `DCFM_FV_SSD_TMR;
        end else if (dis_hit[3]) begin
            cause_val = `DCFM_FV_STO_TERM;
        end else begin
            cause = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            chan_defect_fault <= 1'b0;
            fault_value       <= `DCFM_FV_STOP_REQ;
            stop_a_fault      <= 1'b0;
            stop_a_value      <= `DCFM_FV_STOP_REQ;
        end else if (!chan_defect_fault && cause) begin
            chan_defect_fault <= 1'b1;
            fault_value       <= cause_val;
            stop_a_fault      <= 1'b1;
            stop_a_value      <= `DCFM_FV_STOP_A;
        end else if (chan_defect_fault && ack && !cause) begin
            chan_defect_fault <= 1'b0;
            fault_value       <= `DCFM_FV_STOP_REQ;
            stop_a_fault      <= 1'b0;
            stop_a_value      <= `DCFM_FV_STOP_REQ;
        end
    end
endmodule

// ---- design/dcfm_defs.vh ----
/*
 * Constants of the dual channel fault monitor: fault values, timing defaults.
 * Assumes a 40 MHz system clock; included by bare name.
 */
`ifndef DCFM_DEFS_VH
`define DCFM_DEFS_VH

`define DCFM_FV_W          14
`define DCFM_FV_STOP_REQ   14'h0000
`define DCFM_FV_XCHK_MAX   14'h03e7
`define DCFM_FV_CHATTER    14'h03e8
`define DCFM_FV_INIT_CHG   14'h03e9
`define DCFM_FV_INIT_CHK   14'h03ea
`define DCFM_FV_STO_SEL    14'h07d0
`define DCFM_FV_PULSE_CB   14'h07d1
`define DCFM_FV_SSD_TMR    14'h07d2
`define DCFM_FV_STO_TERM   14'h07d3
`define DCFM_FV_STOP_A     14'h270f
`define DCFM_CHK_MULT      5
`define DCFM_CLK_HZ        40000000
`define DCFM_TOL_MS_DEF    500
`define DCFM_TOL_CYC_DEF   ((`DCFM_TOL_MS_DEF * (`DCFM_CLK_HZ / 1000)))
`define DCFM_TOL_W         32

`endif

// ---- design/dcfm_sync.v ----
/*
 * Two flip-flop synchroniser for a bus of asynchronous levels.
 * Assumes inputs are quasi-static levels; sys_rst clears both stages of the data path.
 */
`include "dcfm_defs.vh"

module dcfm_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;

    always @(posedge clk) begin
        if (sys_rst) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ---- verification/dcfm_mon_checker.sv ----
/* Assertions on the ports of dcfm_monitor.
   Bound from the testbench; one clock, synchronous reset. */
`include "dcfm_defs.vh"
module dcfm_mon_checker #(
    parameter TOL_W = 32
) (
    input logic                  clk,
    input logic                  sys_rst,
    input logic [TOL_W-1:0]      changeover_tolerance_time,
    input logic                  failsafe_digital_input,
    input logic                  failsafe_ack,
    input logic                  ch2_stop_req,
    input logic                  sto_sel_ch1,
    input logic                  sto_sel_ch2,
    input logic                  chan_defect_fault,
    input logic [`DCFM_FV_W-1:0] fault_value,
    input logic                  stop_a_fault,
    input logic [`DCFM_FV_W-1:0] stop_a_value,
    input logic                  sel_monitor_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [TOL_W+2:0] act_cnt;
    always @(posedge clk) begin
        if (sys_rst || !sel_monitor_active)
            act_cnt <= '0;
        else
            act_cnt <= act_cnt + 1'b1;
    end
    sequence s_raise; $rose(chan_defect_fault); endsequence
    sequence s_held; chan_defect_fault ##1 chan_defect_fault; endsequence
    property p_stop_a; chan_defect_fault |-> stop_a_fault && stop_a_value == `DCFM_FV_STOP_A; endproperty
    property p_stop_a_idle; !stop_a_fault |-> stop_a_value == 14'h0000 && !chan_defect_fault; endproperty
    property p_hold; s_held |-> $stable(fault_value); endproperty
    property p_clear; $fell(chan_defect_fault) |-> fault_value == 14'h0000
        && ($past(failsafe_ack, 2) || $past(failsafe_ack, 3) || $past(failsafe_ack, 4)); endproperty
    property p_range; chan_defect_fault |-> fault_value inside {[14'h0000:`DCFM_FV_INIT_CHK],
        [`DCFM_FV_STO_SEL:`DCFM_FV_STO_TERM]}; endproperty
    property p_stop_req; s_raise ##0 (fault_value == 14'h0000) |-> $past(ch2_stop_req, 2); endproperty
    property p_sto_sel; s_raise ##0 (fault_value == `DCFM_FV_STO_SEL)
        |-> $past(sto_sel_ch1, 2) != $past(sto_sel_ch2, 2); endproperty
    property p_chatter; s_raise ##0 (fault_value == `DCFM_FV_CHATTER) |-> $past(sel_monitor_active); endproperty
    property p_mon_start; $rose(sel_monitor_active) |->
        $past(failsafe_digital_input, 2) != $past(failsafe_digital_input, 3)
        || $past(failsafe_digital_input, 3) != $past(failsafe_digital_input, 4)
        || $past(failsafe_digital_input, 4) != $past(failsafe_digital_input, 5); endproperty
    property p_mon_len; sel_monitor_active |-> act_cnt <= changeover_tolerance_time * 5 + 4; endproperty
    a_stop_a: assert property (p_stop_a) else $error("stop A fault wrong");
    a_stop_a_idle: assert property (p_stop_a_idle) else $error("stop A idle wrong");
    a_hold: assert property (p_hold) else $error("fault value changed");
    a_clear: assert property (p_clear) else $error("fault cleared without ack");
    a_range: assert property (p_range) else $error("fault value out of range");
    a_stop_req: assert property (p_stop_req) else $error("value 0 without stop request");
    a_sto_sel: assert property (p_sto_sel) else $error("2000 without discrepancy");
    a_chatter: assert property (p_chatter) else $error("1000 without monitoring");
    a_mon_start: assert property (p_mon_start) else $error("monitoring without edge");
    a_mon_len: assert property (p_mon_len) else $error("monitoring too long");
endmodule

// ---- verification/dcfm_chan2_model.sv ----
/* Second monitoring channel: mirrors channel 1 a cycle late, can disagree.
   Assumes the testbench drives the disagree mask and stop command. */
module dcfm_chan2_model (
    input  logic       clk,
    input  logic [3:0] ch1_state,
    input  logic [3:0] disagree,
    input  logic       stop_cmd,
    output logic [3:0] ch2_state,
    output logic       stop_req
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk) begin
        ch2_state <= ch1_state ^ disagree;
        stop_req  <= stop_cmd;
    end
endmodule

// ---- verification/testbench.sv ----
/* Self-checking testbench of dcfm_monitor with the channel 2 model.
   Assumes the tolerance port is in clock cycles. */
`include "dcfm_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam TOL = 4;
    logic        clk, sys_rst, sel, ack, stop_cmd, xerr, ch2_stop, fault, stop_a, mon;
    logic [9:0]  xcode;
    logic [3:0]  ch1, mask, ch2;
    logic [13:0] fv, sav;
    logic [31:0] tol;
    integer      seed, miscompares, checked, i;
    dcfm_chan2_model u_ch2 (.clk(clk), .ch1_state(ch1), .disagree(mask), .stop_cmd(stop_cmd),
        .ch2_state(ch2), .stop_req(ch2_stop));
    dcfm_monitor DUT (.clk(clk), .sys_rst(sys_rst), .changeover_tolerance_time(tol),
        .failsafe_digital_input(sel), .failsafe_ack(ack), .ch2_stop_req(ch2_stop), .xchk_err(xerr),
        .xchk_code(xcode), .sto_sel_ch1(ch1[0]), .sto_sel_ch2(ch2[0]), .pulse_cb_ch1(ch1[1]),
        .pulse_cb_ch2(ch2[1]), .ssd_tmr_ch1(ch1[2]), .ssd_tmr_ch2(ch2[2]), .sto_term_p1(ch1[3]),
        .sto_term_p2(ch2[3]), .chan_defect_fault(fault), .fault_value(fv), .stop_a_fault(stop_a),
        .stop_a_value(sav), .sel_monitor_active(mon));
    function automatic logic [13:0] xexp(input logic [9:0] c);
        xexp = (c == 10'h000) ? 14'h0001 : (c > 10'h3e7) ? `DCFM_FV_XCHK_MAX : {4'h0, c};
    endfunction
    task finish_test;
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task cmp_val(input logic [13:0] e, input logic [13:0] g);
        checked = checked + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task cmp_flag(input logic e, input logic g);
        cmp_val({13'h0, e}, {13'h0, g});
    endtask
    task wait_fault(input logic lvl);
        for (int n = 0; n < 60 && fault !== lvl; n++) begin
            @(posedge clk);
            #1;
        end
        if (fault !== lvl) begin
            miscompares = miscompares + 1;
            finish_test;
        end
    endtask
    task expect_fault(input logic [13:0] v);
        wait_fault(1'b1);
        cmp_val(v, fv);
        cmp_flag(1'b1, stop_a);
        cmp_val(`DCFM_FV_STOP_A, sav);
    endtask
    task clear_all;
        @(posedge clk);
        {mask, stop_cmd, xerr, ack} <= 7'h01;
        wait_fault(1'b0);
        cmp_val(14'h0000, fv);
        @(posedge clk);
        ack <= 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        seed = 32'hc11eb18b;
        miscompares = 0;
        checked = 0;
        {sys_rst, sel, ack, stop_cmd, xerr, xcode, ch1, mask} = 23'h400000;
        tol = TOL;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) begin
            repeat (8) @(posedge clk);
            ch1 <= 4'($random(seed));
        end
        #1 cmp_flag(1'b0, fault);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            mask <= 4'h1 << i;
            expect_fault(`DCFM_FV_STO_SEL + 14'(i));
            @(posedge clk);
            ack <= 1'b1;
            repeat (10) @(posedge clk);
            #1 cmp_flag(1'b1, fault);
            clear_all;
        end
        @(posedge clk);
        stop_cmd <= 1'b1;
        expect_fault(14'h0000);
        @(posedge clk);
        {xerr, xcode} <= 11'h405;
        repeat (8) @(posedge clk);
        #1 cmp_val(14'h0000, fv);
        clear_all;
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            xcode <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : (i == 2) ? 10'h3e7 :
                     10'h001 + 10'($unsigned($random(seed)) % 998);
            xerr <= 1'b1;
            @(posedge clk);
            expect_fault(xexp(xcode));
            clear_all;
        end
        for (i = 0; i < 15; i++) begin
            repeat (2) @(posedge clk);
            sel <= ~sel;
            if (i == 4)
                #1 cmp_flag(1'b1, mon);
        end
        expect_fault(`DCFM_FV_CHATTER);
        clear_all;
        @(posedge clk);
        sel <= ~sel;
        repeat (5) @(posedge clk);
        #1 cmp_flag(1'b1, mon);
        repeat (5 * TOL + 10) @(posedge clk);
        #1 cmp_flag(1'b0, mon);
        cmp_flag(1'b0, fault);
        finish_test;
    end
endmodule
bind dcfm_monitor dcfm_mon_checker #(.TOL_W(TOL_W)) u_chk (.clk, .sys_rst, .changeover_tolerance_time,
    .failsafe_digital_input, .failsafe_ack, .ch2_stop_req, .sto_sel_ch1, .sto_sel_ch2, .chan_defect_fault,
    .fault_value, .stop_a_fault, .stop_a_value, .sel_monitor_active);
